//--- hw/gms_pkg.sv
/*
  Constants shared by the gain/mux serial control block.
  Assumes a 16-bit command frame.
*/
package gms_pkg;
  // ==========================================
  // Frame and field layout
  localparam int          FRAME_BITS   = 16;
  localparam int          FIELD_W      = 4;
  localparam int          GAIN_LSB     = 4;
  localparam int          CHAN_LSB     = 0;
  localparam int          PREFIX_LSB   = 8;
  // ==========================================
  // Command words
  localparam logic [7:0]  WRITE_PREFIX = 8'h2a;
  localparam logic [15:0] READ_CMD     = 16'h6a00;
  localparam logic [15:0] SHUTDOWN_ENTER_CMD = 16'he1f1;
  localparam logic [15:0] SHUTDOWN_EXIT_CMD  = 16'he100;
  // ==========================================
  // Reset values and read-back upper byte
  localparam logic [3:0]  GAIN_RST     = 4'h0;
  localparam logic [3:0]  CHAN_RST     = 4'h0;
  localparam logic [7:0]  READ_UPPER   = 8'h00;
  // Commit sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FRAME  = 3'b010,
    ST_COMMIT = 3'b100
  } gms_state_t;
endpackage : gms_pkg

//--- hw/gms_link_shift.sv
/*
  Serial-clock side of the control port: shift register,
  frame bit counter and data output bit.
  Assumes chip select low frames the serial clock edges.
*/
`timescale 1ns/1ns
module gms_link_shift #(
  parameter int P_WIDTH = 16
) (
  // Link clock and resets
  input  wire logic               i_sclk,
  input  wire logic               i_rst_b,
  input  wire logic               i_cs_n,
  // Serial data
  input  wire logic               i_sdi,
  output logic                    o_sdo,
  // Word loaded at frame start
  input  wire logic               i_load_en,
  input  wire logic [P_WIDTH-1:0] i_load_word,
  // Frame result, static once the clock stops
  output logic [P_WIDTH-1:0]      o_shift,
  output logic [$clog2(P_WIDTH)-1:0] o_count,
  output logic                    o_full,
  // Flips once for every frame that carried clocks
  output logic                    o_frame_tag
);
  localparam int CW = $clog2(P_WIDTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_MAX = CW'(P_WIDTH - 1);

  initial
  begin
    if (P_WIDTH < 2 || (1 << CW) != P_WIDTH)
      $error("P_WIDTH must be a power of two");
  end

  // ==========================================
  // Rising-edge shifter
  logic               frame_rst_b;
  logic               first_reg, first_next;
  logic               hold_reg, hold_next;
  logic               full_reg, full_next;
  logic               tag_reg, tag_next;
  logic [CW-1:0]      count_reg, count_next;
  logic [P_WIDTH-1:0] shift_reg, shift_next, src;

  assign frame_rst_b = i_rst_b & ~i_cs_n;

  // Next values on the sampling edge
  always_comb
  begin
    // [R16] Load or pass through
    src        = (!first_reg && i_load_en) ? i_load_word : shift_reg;
    // [R2] Sample on rising edge
    shift_next = {src[P_WIDTH-2:0], i_sdi};
    hold_next  = src[P_WIDTH-1];
    first_next = 1'b1;
    // [R4] Count frame clocks
    count_next = first_reg ? count_reg + CNT_ONE : CNT_ONE;
    full_next  = first_reg & (full_reg | (count_reg == CNT_MAX));
    // [R4] Tag flips on the first clock, so a clockless frame cannot reuse old data
    tag_next   = first_reg ? tag_reg : ~tag_reg;
    // Edges with chip select high, as on a polarity swap, leave the result alone
    if (i_cs_n)
    begin
      shift_next = shift_reg;
      hold_next  = hold_reg;
      count_next = count_reg;
      full_next  = full_reg;
      tag_next   = tag_reg;
    end
  end

  // Frame flag cleared while chip select is high
  always_ff @(posedge i_sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
      first_reg <= 1'b0;
    else
      first_reg <= first_next;
  end

  // Data kept when the frame ends
  always_ff @(posedge i_sclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shift_reg <= '0;
      count_reg <= '0;
      full_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      tag_reg   <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      full_reg  <= full_next;
      hold_reg  <= hold_next;
      tag_reg   <= tag_next;
    end
  end

  // ==========================================
  // Falling-edge output
  logic out_reg, out_next;
  logic fell_reg, fell_next;

  // [R2] Change on falling edge
  always_comb
  begin
    out_next  = shift_reg[P_WIDTH-1];
    fell_next = first_reg;
  end

  always_ff @(negedge i_sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
    begin
      out_reg  <= 1'b0;
      fell_reg <= 1'b0;
    end
    else
    begin
      out_reg  <= out_next;
      fell_reg <= fell_next;
    end
  end

  // [R3] First bit ready before first edge
  assign o_sdo   = fell_reg ? out_reg : (first_reg ? hold_reg : src[P_WIDTH-1]);
  assign o_shift = shift_reg;
  assign o_count = count_reg;
  assign o_full  = full_reg;
  assign o_frame_tag = tag_reg;

  // ==========================================
  // Checks
  chk_count_wrap: assert property (@(posedge i_sclk) disable iff (!frame_rst_b) // [R4]
    first_reg && count_reg == CNT_MAX |=> full_reg && count_reg == '0)
    else $error("Bit count did not wrap into full");
  chk_rise_sample: assert property (@(posedge i_sclk) disable iff (!frame_rst_b) // [R2]
    first_reg |=> shift_reg[0] == $past(i_sdi))
    else $error("Data not sampled on rising edge");
endmodule : gms_link_shift

//--- hw/gms_gain_mux_spi_slave.sv
/*
  Serial control port of a programmable gain amplifier with
  input multiplexer: frame check, commit and read-back.
  Assumes the serial clock stops while chip select is high and
  chip select stays high at least three system clocks.
*/
// Summary of operation
// [R1] Modes 0,0 and 1,1 both work with no setting in the device.
// [R2] Data is sampled on rising serial clock edges and changed on falling ones.
// [R3] The first sample edge follows chip select per the clock phase in use.
// [R4] A frame counts only if its clock total is a nonzero multiple of sixteen.
// [R5] The master resynchronises by sending a frame with a bad clock count.
// [R6] The received word takes effect only at the chip select rising edge.
// [R7] The data output is released whenever chip select is high.
// [R8] The four-wire output is driven for the whole of a chip select low time.
// [R9] An undriven data input reads as zero.
// [R10] Three-wire data pin drives only after a valid read request.
// [R11] A write carries prefix 0x2a, gain in bits 7 to 4 and channel in 3 to 0.
// [R12] Shutdown enter sets shutdown; exit or any write clears it.
// [R13] Reset clears gain and channel to zero.
// [R14] A low hardware enable forces shutdown.
// [R15] A read word makes the next valid frame shift out the gain and channel.
// [R16] Four-wire data passes to the output sixteen clocks later.
`timescale 1ns/1ns
module gms_gain_mux_spi_slave #(
  parameter bit P_THREE_WIRE = 1'b0,
  parameter bit P_HW_ENABLE  = 1'b1
) (
  // System clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Serial link
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  // Hardware enable pin
  input  wire logic       i_hw_enable,
  // Configuration out
  output logic [3:0]      o_gain,
  output logic [3:0]      o_channel,
  output logic            o_shutdown,
  output logic            o_read_armed,
  output logic            o_frame_accepted
);
  localparam int W  = gms_pkg::FRAME_BITS;
  localparam int FW = gms_pkg::FIELD_W;
  localparam int CW = $clog2(W);

  initial
  begin
    if (FW != 4)
      $error("Field width must be four");
  end

  // ==========================================
  // Pin synchronisers
  logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
  logic en_meta_reg, en_sync_reg;

  // Two flops per pin, then an edge history flop on chip select
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      en_meta_reg <= 1'b1;
      en_sync_reg <= 1'b1;
    end
    else
    begin
      cs_meta_reg <= i_cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      en_meta_reg <= i_hw_enable;
      en_sync_reg <= en_meta_reg;
    end
  end

  // ==========================================
  // Link side
  logic [W-1:0]  link_shift;
  logic [CW-1:0] link_count;
  logic          link_full;
  logic          link_tag;
  logic          link_sdo;
  logic          sdi_eff;
  logic [W-1:0]  read_word;
  logic [3:0]    gain_reg, gain_next;
  logic [3:0]    chan_reg, chan_next;
  logic          armed_reg, armed_next;

  // [R9] Own drive masks input to zero
  assign sdi_eff   = (P_THREE_WIRE && o_sdo_oe) ? 1'b0 : i_sdi;
  // [R15] Read-back word
  assign read_word = {gms_pkg::READ_UPPER, gain_reg, chan_reg};

  // [R1] Rising-edge sampler serves both modes
  gms_link_shift #(
    .P_WIDTH     (W)
  ) u_link (
    .i_sclk      (i_sclk),
    .i_rst_b     (i_rst_b),
    .i_cs_n      (i_cs_n),
    .i_sdi       (sdi_eff),
    .o_sdo       (link_sdo),
    .i_load_en   (armed_reg),
    .i_load_word (read_word),
    .o_shift     (link_shift),
    .o_count     (link_count),
    .o_full      (link_full),
    .o_frame_tag (link_tag)
  );

  // Output pin follows chip select directly
  always_comb
  begin
    o_sdo    = link_sdo;
    // [R7] Released while chip select high
    // [R8] Four-wire drives whole frame
    // [R10] Three-wire drives after read
    o_sdo_oe = ~i_cs_n & (~P_THREE_WIRE | armed_reg);
  end

  // ==========================================
  // Commit sequencer
  gms_pkg::gms_state_t state_reg, state_next;
  logic        frame_ok;
  logic        is_write;
  logic        sw_sd_reg, sw_sd_next;
  logic        sd_reg, sd_next;
  logic        acc_reg, acc_next;
  logic        tag_seen_reg, tag_seen_next;

  // [R4] Nonzero multiple of frame length
  // An unchanged tag means no clocks since the last commit: refuse it
  assign frame_ok = link_full && (link_count == '0) && (link_tag != tag_seen_reg);
  assign is_write = link_shift[gms_pkg::PREFIX_LSB +: 8] == gms_pkg::WRITE_PREFIX;

  // Next state and configuration
  always_comb
  begin
    state_next = state_reg;
    gain_next  = gain_reg;
    chan_next  = chan_reg;
    sw_sd_next = sw_sd_reg;
    armed_next = armed_reg;
    acc_next   = 1'b0;
    tag_seen_next = tag_seen_reg;
    case (state_reg)
      gms_pkg::ST_IDLE:
      begin
        if (!cs_sync_reg)
          state_next = gms_pkg::ST_FRAME;
      end
      gms_pkg::ST_FRAME:
      begin
        // [R6] Wait for chip select rise
        if (cs_sync_reg && !cs_prev_reg)
          state_next = gms_pkg::ST_COMMIT;
      end
      gms_pkg::ST_COMMIT:
      begin
        state_next = gms_pkg::ST_IDLE;
        // Every frame end consumes the link result, good or bad
        tag_seen_next = link_tag;
        // [R5] Bad count leaves all unchanged
        if (frame_ok)
        begin
          acc_next   = 1'b1;
          // [R15] Arm read-back for next frame
          armed_next = (link_shift == gms_pkg::READ_CMD);
          // [R11] Write fields
          if (is_write)
          begin
            gain_next  = link_shift[gms_pkg::GAIN_LSB +: 4];
            chan_next  = link_shift[gms_pkg::CHAN_LSB +: 4];
            sw_sd_next = 1'b0;
          end
          // [R12] Shutdown enter and exit
          else if (link_shift == gms_pkg::SHUTDOWN_ENTER_CMD)
            sw_sd_next = 1'b1;
          else if (link_shift == gms_pkg::SHUTDOWN_EXIT_CMD)
            sw_sd_next = 1'b0;
        end
      end
      default:
      begin
        state_next = gms_pkg::ST_IDLE;
      end
    endcase
    // [R14] Hardware enable forces shutdown
    sd_next = sw_sd_next | (P_HW_ENABLE & ~en_sync_reg);
  end

  // Register the sequencer
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= gms_pkg::ST_IDLE;
      // [R13] Reset to unity gain, channel zero
      gain_reg  <= gms_pkg::GAIN_RST;
      chan_reg  <= gms_pkg::CHAN_RST;
      sw_sd_reg <= 1'b0;
      sd_reg    <= 1'b0;
      armed_reg <= 1'b0;
      acc_reg   <= 1'b0;
      tag_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      gain_reg  <= gain_next;
      chan_reg  <= chan_next;
      sw_sd_reg <= sw_sd_next;
      sd_reg    <= sd_next;
      armed_reg <= armed_next;
      acc_reg   <= acc_next;
      tag_seen_reg <= tag_seen_next;
    end
  end

  assign o_gain           = gain_reg;
  assign o_channel        = chan_reg;
  assign o_shutdown       = sd_reg;
  assign o_read_armed     = armed_reg;
  assign o_frame_accepted = acc_reg;

  // ==========================================
  // Checks
  logic in_commit;
  assign in_commit = state_reg == gms_pkg::ST_COMMIT;

  sequence s_good_write;
    in_commit && frame_ok && is_write;
  endsequence

  sequence s_bad_frame;
    in_commit && !frame_ok;
  endsequence

  chk_write_fields: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R11]
    s_good_write |=> o_gain == $past(link_shift[7:4]) && o_channel == $past(link_shift[3:0]))
    else $error("Write fields not committed");
  chk_bad_frame: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R4]
    s_bad_frame |=> $stable(o_gain) && $stable(o_channel) && !o_frame_accepted)
    else $error("Bad frame changed configuration");
  chk_commit_only: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
    !in_commit |=> $stable(gain_reg) && $stable(chan_reg))
    else $error("Configuration changed outside commit");
  chk_commit_reach: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R6]
    state_reg == gms_pkg::ST_FRAME && cs_sync_reg && !cs_prev_reg |-> ##1 in_commit ##1 !in_commit)
    else $error("Commit did not follow chip select rise");
  chk_sd_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R12]
    in_commit && frame_ok && link_shift == gms_pkg::SHUTDOWN_ENTER_CMD |=> o_shutdown)
    else $error("Shutdown not entered");
  chk_sd_leave: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R12]
    s_good_write ##0 en_sync_reg |=> !o_shutdown)
    else $error("Write did not leave shutdown");
  chk_hw_force: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R14]
    P_HW_ENABLE && !en_sync_reg |=> o_shutdown)
    else $error("Enable pin low without shutdown");
  chk_read_arm: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R15]
    in_commit && frame_ok |=> o_read_armed == ($past(link_shift) == gms_pkg::READ_CMD))
    else $error("Read arming wrong");
  chk_oe_release: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R7]
    i_cs_n |-> !o_sdo_oe)
    else $error("Output driven with chip select high");
  chk_oe_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R10]
    !i_cs_n |-> o_sdo_oe == (!P_THREE_WIRE || armed_reg))
    else $error("Output enable wrong in frame");
endmodule : gms_gain_mux_spi_slave

//--- verif/gms_spi_host.sv
/*
  Host serial master model for the gain/mux control port.
  Assumes the bench calls frame() only while chip select is high.
*/
`timescale 1ns/1ns
module gms_spi_host (
  // Device data out
  input  wire logic i_sdo,
  // Link pins to device
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  logic        drv;
  logic        bit_v;
  logic [31:0] rx;
  // ==========================================
  // Pin levels
  // Released line is pulled low
  assign o_sdi = drv ? bit_v : 1'b0;
  // Idle state
  initial
  begin
    o_sclk = 1'b0;
    // Chip select moves late in the time step so a clocked monitor sees it settled
    o_cs_n <= 1'b1;
    drv    = 1'b0;
    bit_v  = 1'b0;
    rx     = 32'h0;
  end
  // ==========================================
  // Frame of n clocks, MSB of w[n-1:0] first, 6 ns link clock
  // Either mode, data moves on falling edges
  task automatic frame(input bit cpol, input int n, input logic [31:0] w);
    o_sclk = cpol;
    #20;
    o_cs_n <= 1'b0;
    drv    = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sclk = 1'b0;
      bit_v  = w[i];
      #3;
      o_sclk = 1'b1;
      rx     = {rx[30:0], i_sdo};
      #3;
    end
    o_sclk = cpol;
    #3;
    drv    = 1'b0;
    o_cs_n <= 1'b1;
    #100;
  endtask : frame
endmodule : gms_spi_host

//--- verif/gms_gain_mux_spi_slave_tb_top.sv
/*
  Self-checking bench for the gain/mux serial control port.
  Assumes the host model gms_spi_host, a four-wire device and a
  three-wire device without enable pin on the same link pins.
*/
`timescale 1ns/1ns
module gms_gain_mux_spi_slave_tb_top;
  logic        i_clk, i_rst_b, i_hw_enable;
  logic        sclk, cs_n, sdi, sdo, sdo_oe;
  logic [3:0]  gain, chan, g, c;
  logic        shut, armed, acc, sd, arm;
  logic        oe3;
  logic [7:0]  held;
  logic [31:0] seed, w;
  logic [9:0]  q[$];
  int          errors, compares;
  int          bad[5] = '{0, 8, 15, 17, 31};

  // ==========================================
  // Device and host
  gms_gain_mux_spi_slave dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_hw_enable(i_hw_enable),
    .o_gain(gain), .o_channel(chan), .o_shutdown(shut),
    .o_read_armed(armed), .o_frame_accepted(acc)
  );
  gms_spi_host host (.i_sdo(sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
  // Three-wire variant, watched for its data pin direction
  gms_gain_mux_spi_slave #(
    .P_THREE_WIRE(1'b1), .P_HW_ENABLE(1'b0)
  ) dut_3w (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(), .o_sdo_oe(oe3), .i_hw_enable(i_hw_enable),
    .o_gain(), .o_channel(), .o_shutdown(),
    .o_read_armed(), .o_frame_accepted()
  );

  // System clock, 10 ns
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================
  // Helpers
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : ck

  task automatic final_report;
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Note the expected outcome of a valid frame, then send it
  task automatic cmd(input bit cpol, input int n, input logic [31:0] wd);
    logic [15:0] v;
    v = wd[15:0];
    if (n > 0 && n % 16 == 0)
    begin
      arm = (v == gms_pkg::READ_CMD);
      if (v[15:8] == gms_pkg::WRITE_PREFIX)
      begin
        g  = v[7:4];
        c  = v[3:0];
        sd = 1'b0;
      end
      if (v == gms_pkg::SHUTDOWN_ENTER_CMD)
        sd = 1'b1;
      if (v == gms_pkg::SHUTDOWN_EXIT_CMD)
        sd = 1'b0;
      q.push_back({g, c, sd, arm});
    end
    host.frame(cpol, n, wd);
  endtask : cmd

  // Mode 0,0 frame with a look at the three-wire pin direction inside it
  task automatic cmd_tw(input logic [31:0] wd, input logic exp);
    fork
      cmd(1'b0, 16, wd);
      begin
        @(negedge cs_n);
        #10;
        ck({15'h0, oe3}, {15'h0, exp});
      end
    join
  endtask : cmd_tw

  // ==========================================
  // Monitor: commit pulses take the oldest note; pins checked each cycle
  always @(negedge i_clk)
  begin
    if (acc === 1'b1)
    begin
      if (q.size() == 0)
        ck(16'h1, 16'h0);
      else
        ck({6'h0, gain, chan, shut, armed}, {6'h0, q.pop_front()});
    end
    if (i_rst_b === 1'b1)
      ck({15'h0, sdo_oe}, {15'h0, ~cs_n});
    if (cs_n === 1'b0)
      ck({8'h0, gain, chan}, {8'h0, held});
    else
      held = {gain, chan};
  end

  // Watchdog
  initial
  begin
    #50000;
    errors++;
    final_report();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    errors      = 0;
    compares    = 0;
    seed        = 32'd68257;
    {g, c, sd, arm} = 10'h0;
    held        = 8'h0;
    i_rst_b     = 1'b0;
    i_hw_enable = 1'b1;
    repeat (16) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (5) @(negedge i_clk);
    ck({8'h0, gain, chan}, 16'h0);
    ck({14'h0, shut, armed}, 16'h0);
    // Random writes, mode 0,0 then 1,1
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      cmd(i > 3, 16, {16'h0, gms_pkg::WRITE_PREFIX, seed[7:0]});
    end
    // Bad clock counts, then a resync write
    foreach (bad[i])
      cmd(1'b0, bad[i], 32'h00002aff);
    cmd(1'b0, 16, 32'h00002a5c);
    // Long frame: last 16 bits command, first 16 echoed out
    seed = lfsr(seed);
    w    = {seed[15:0], gms_pkg::WRITE_PREFIX, seed[23:16]};
    cmd(1'b0, 32, w);
    ck(host.rx[15:0], w[31:16]);
    // Read-back in the frame after a read command
    cmd_tw({16'h0, gms_pkg::READ_CMD}, 1'b0);
    cmd_tw(32'h0, 1'b1);
    ck(host.rx[15:0], {gms_pkg::READ_UPPER, g, c});
    // Shutdown enter, exit, enter, cleared by a write
    cmd(1'b0, 16, {16'h0, gms_pkg::SHUTDOWN_ENTER_CMD});
    cmd(1'b0, 16, {16'h0, gms_pkg::SHUTDOWN_EXIT_CMD});
    cmd(1'b0, 16, {16'h0, gms_pkg::SHUTDOWN_ENTER_CMD});
    cmd(1'b0, 16, 32'h00002a71);
    // Hardware enable forces shutdown
    i_hw_enable = 1'b0;
    repeat (6) @(negedge i_clk);
    ck({15'h0, shut}, 16'h1);
    i_hw_enable = 1'b1;
    repeat (6) @(negedge i_clk);
    ck({15'h0, shut}, {15'h0, sd});
    ck(16'(q.size()), 16'h0);
    final_report();
  end
endmodule : gms_gain_mux_spi_slave_tb_top
